// File: src/uepr_pkg.sv
// Package for the endpoint packet-ready interrupt block.
// Assumes a 32-bit AXI4-Lite register bus and a USB engine giving event pulses.
package uepr_pkg;
  // Register byte offsets
  localparam logic [7:0] OFF_PKT_READY = 8'h00; // Control tx ready + status view
  localparam logic [7:0] OFF_IRQ_EN = 8'h04; // Control tx enable
  localparam logic [7:0] OFF_IRQ_EN2 = 8'h08; // Endpoint 1..3 tx enables
  localparam logic [7:0] OFF_EP_STAT = 8'h0c; // Endpoint 1/2 rx ready, w1c
  localparam logic [7:0] OFF_RX_EN = 8'h10; // Endpoint 1/2 rx enables
  localparam logic [7:0] OFF_IRQ_STAT = 8'h14; // Sticky causes, read clears
  localparam logic [7:0] OFF_IRQ_MASK = 8'h18; // Mask of live causes to the interrupt pins
  localparam logic [7:0] OFF_EP_DIR = 8'h1c; // Endpoint 1/2 direction, 1 = tx
  localparam logic [7:0] OFF_RX_CNT1 = 8'h20; // Endpoint 1 rx byte count
  localparam logic [7:0] OFF_RX_CNT2 = 8'h24; // Endpoint 2 rx byte count
  // Field positions
  localparam int CTL_TX_BIT = 4; // Control tx ready in packet ready register
  localparam int EP_TX_LSB = 0; // Endpoint 1..3 tx bits 0..2
  localparam int EP_RX_LSB = 0; // Endpoint 1/2 rx bits 0..1
  // Sticky status layout: [0] ctl tx, [3:1] ep tx, [5:4] ep rx
  localparam int ST_W = 6;
  localparam logic [ST_W-1:0] MASK_RST = 6'h3f;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  localparam int CNT_W = 7; // Byte count, up to 64

  // Events from the USB engine, one-cycle pulses
  typedef struct packed {
    logic ctl_data_stage; // Control read entered data stage
    logic [2:0] tx_ack; // Host acked packet on ep 1..3
    logic ctl_tx_ack; // Host acked control packet
    logic [1:0] rx_eop_ok; // EOP seen, data stored clean on ep 1/2
    logic [1:0][CNT_W-1:0] rx_count; // Length of received packet
  } uepr_usb_ev_t;

  // Commands to the USB engine, one-cycle pulses
  typedef struct packed {
    logic ctl_send; // Control packet armed
    logic [2:0] ep_send; // Endpoint packet armed
    logic [1:0] rx_free; // Rx FIFO handed back
  } uepr_usb_cmd_t;
endpackage

// File: src/uepr_top.sv
// Packet-ready flags, enables and interrupt for the USB endpoints.
// Assumes the USB engine pulses events in the sys_clk_i domain.
// Assumes firmware writes registers over AXI4-Lite using byte lane 0 only.
// What this block does
// - Clear control tx ready entering data stage
// - Control tx interrupt only when enabled
// - Later packets need host ack first
// - Write one arms packet, drops interrupt
// - Short packets armed the same way
// - Rx ready set on clean EOP
// - EOP ends full and short packets
// - Rx interrupt only when enabled
// - Rx ready is write-one-to-clear
// - Clear ep tx ready when FIFO free
// - Ep tx interrupt only when enabled
// - One active-low interrupt, causes maskable
//
// Our own choices: the AXI4-Lite register port and the register addresses.
module uepr_top
  import uepr_pkg::*;
(
  // Clock and reset
  input wire logic sys_clk_i,
  input wire logic resetn_i,
  // AXI4-Lite write address
  input wire logic [7:0] s_axi_awaddr_i,
  input wire logic s_axi_awvalid_i,
  output logic s_axi_awready_o,
  // AXI4-Lite write data
  input wire logic [31:0] s_axi_wdata_i,
  input wire logic [3:0] s_axi_wstrb_i,
  input wire logic s_axi_wvalid_i,
  output logic s_axi_wready_o,
  // AXI4-Lite write response
  output logic [1:0] s_axi_bresp_o,
  output logic s_axi_bvalid_o,
  input wire logic s_axi_bready_i,
  // AXI4-Lite read address
  input wire logic [7:0] s_axi_araddr_i,
  input wire logic s_axi_arvalid_i,
  output logic s_axi_arready_o,
  // AXI4-Lite read data
  output logic [31:0] s_axi_rdata_o,
  output logic [1:0] s_axi_rresp_o,
  output logic s_axi_rvalid_o,
  input wire logic s_axi_rready_i,
  // USB engine side
  input wire uepr_pkg::uepr_usb_ev_t usb_ev_i,
  output uepr_pkg::uepr_usb_cmd_t usb_cmd_o,
  // Interrupt to the microcontroller
  output logic irq_out_n_o,
  output logic irq_o
);
  import uepr_pkg::*;

  // Body import so the package names read bare below
  // A low tx flag is the request to fill the FIFO
  // Ready flags: high means the packet is owned by hardware / data waiting
  logic ctl_tx_ready; // 1 = armed, 0 = FIFO writable
  logic [2:0] ep_tx_ready; // Same for endpoints 1..3
  logic [1:0] ep_rx_ready; // 1 = packet waiting for firmware
  logic ctl_in_data; // Control read data stage active
  logic [2:0] ep_tx_first; // Next tx is the first of a run
  logic irq_en_ctl; // Control tx enable
  logic [2:0] irq_en2; // Endpoint tx enables
  logic [1:0] rx_en; // Endpoint rx enables
  logic [1:0] ep_dir_tx; // Endpoint 1/2 used as transmitter
  logic [ST_W-1:0] irq_stat; // Sticky causes
  logic [ST_W-1:0] irq_mask; // Mask, 1 = pass
  logic [1:0][CNT_W-1:0] rx_cnt; // Received byte counts
  // Endpoint 3 has no receive path, so it is always a transmitter
  logic [2:0] ep_is_tx;

  // Bus write capture, address and data may arrive in either order
  logic aw_held;
  logic w_held;
  logic [7:0] aw_addr;
  logic [31:0] w_data;
  logic [3:0] w_strb;
  logic wr_fire;
  logic wr_lane0;
  logic [7:0] wr_byte;
  // Read path and interrupt vectors
  logic rd_fire;
  logic [31:0] next_rdata;
  logic next_rerr;
  logic [ST_W-1:0] ev_vec;
  logic [ST_W-1:0] rd_clr;
  logic [ST_W-1:0] pend;

  assign wr_fire = aw_held && w_held && !s_axi_bvalid_o;
  assign wr_lane0 = wr_fire && w_strb[0];
  assign wr_byte = w_data[7:0];
  assign rd_fire = s_axi_arvalid_i && s_axi_arready_o;
  assign ep_is_tx = {1'b1, ep_dir_tx}; // Direction per endpoint 1..3

  // Address channel capture
  // Ready is offered while nothing is held, so AW may come before W
  // Trade-off: an idle cycle follows each write before a new address is taken
  always_ff @(posedge sys_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      aw_held <= 1'b0;
      aw_addr <= 8'h00;
      s_axi_awready_o <= 1'b0;
    end else begin
      s_axi_awready_o <= !aw_held && !s_axi_awvalid_i ? 1'b1 : !aw_held && !s_axi_awready_o;
      if (s_axi_awvalid_i && s_axi_awready_o) begin
        aw_held <= 1'b1;
        aw_addr <= s_axi_awaddr_i;
        s_axi_awready_o <= 1'b0;
      end else if (wr_fire) begin
        aw_held <= 1'b0;
      end
    end
  end

  // Data channel capture
  // Strobes are kept, but only lane 0 carries register bits
  always_ff @(posedge sys_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      w_held <= 1'b0;
      w_data <= 32'h0;
      w_strb <= 4'h0;
      s_axi_wready_o <= 1'b0;
    end else begin
      s_axi_wready_o <= !w_held && !(s_axi_wvalid_i && s_axi_wready_o);
      if (s_axi_wvalid_i && s_axi_wready_o) begin
        w_held <= 1'b1;
        w_data <= s_axi_wdata_i;
        w_strb <= s_axi_wstrb_i;
      end else if (wr_fire) begin
        w_held <= 1'b0;
      end
    end
  end

  // Write response, one cycle after both halves are held
  // A new write cannot fire while the previous response still waits
  always_ff @(posedge sys_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      s_axi_bvalid_o <= 1'b0;
      s_axi_bresp_o <= RESP_OKAY;
    end else if (wr_fire) begin
      s_axi_bvalid_o <= 1'b1;
      s_axi_bresp_o <= (aw_addr > OFF_RX_CNT2 || aw_addr[1:0] != 2'h0) ? RESP_SLVERR : RESP_OKAY;
    end else if (s_axi_bready_i) begin
      s_axi_bvalid_o <= 1'b0;
    end
  end

  // Read data mux
  // Decodes the live address; only its value at the handshake edge matters
  // Ep tx ready flags are shown beside the direction bits
  always_comb begin
    next_rdata = 32'h0;
    next_rerr = 1'b0;
    unique case (s_axi_araddr_i)
      OFF_PKT_READY: next_rdata[CTL_TX_BIT] = ctl_tx_ready;
      OFF_IRQ_EN: next_rdata[CTL_TX_BIT] = irq_en_ctl;
      OFF_IRQ_EN2: next_rdata[EP_TX_LSB +: 3] = irq_en2;
      OFF_EP_STAT: next_rdata[EP_RX_LSB +: 2] = ep_rx_ready;
      OFF_RX_EN: next_rdata[1:0] = rx_en;
      OFF_IRQ_STAT: next_rdata[ST_W-1:0] = irq_stat;
      OFF_IRQ_MASK: next_rdata[ST_W-1:0] = irq_mask;
      OFF_EP_DIR: next_rdata = {24'h0, 1'b0, ep_tx_ready, 2'h0, ep_dir_tx};
      OFF_RX_CNT1: next_rdata[CNT_W-1:0] = rx_cnt[0];
      OFF_RX_CNT2: next_rdata[CNT_W-1:0] = rx_cnt[1];
      default: next_rerr = 1'b1; // Unmapped answers SLVERR
    endcase
  end

  // Read channel, one read at a time
  // Arready stays low for a cycle after each response; simpler than a skid
  always_ff @(posedge sys_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      s_axi_arready_o <= 1'b0;
      s_axi_rvalid_o <= 1'b0;
      s_axi_rdata_o <= 32'h0;
      s_axi_rresp_o <= RESP_OKAY;
    end else if (rd_fire) begin
      s_axi_arready_o <= 1'b0;
      s_axi_rvalid_o <= 1'b1;
      s_axi_rdata_o <= next_rdata;
      s_axi_rresp_o <= next_rerr ? RESP_SLVERR : RESP_OKAY;
    end else if (s_axi_rvalid_o) begin
      s_axi_arready_o <= 1'b0;
      if (s_axi_rready_i) s_axi_rvalid_o <= 1'b0;
    end else begin
      s_axi_arready_o <= 1'b1;
    end
  end

  // Enable, mask and direction registers
  // Exact offsets only, so an unaligned write changes nothing
  always_ff @(posedge sys_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      irq_en_ctl <= 1'b0;
      irq_en2 <= 3'h0;
      rx_en <= 2'h0;
      ep_dir_tx <= 2'h0;
      irq_mask <= MASK_RST;
    end else if (wr_lane0) begin
      if (aw_addr == OFF_IRQ_EN) irq_en_ctl <= wr_byte[CTL_TX_BIT];
      if (aw_addr == OFF_IRQ_EN2) irq_en2 <= wr_byte[EP_TX_LSB +: 3];
      if (aw_addr == OFF_RX_EN) rx_en <= wr_byte[1:0];
      if (aw_addr == OFF_EP_DIR) ep_dir_tx <= wr_byte[1:0];
      if (aw_addr == OFF_IRQ_MASK) irq_mask <= wr_byte[ST_W-1:0];
    end
  end

  // Control endpoint transmit flag; firmware sets it once the packet is loaded
  // The data stage pulse wins over a same-cycle arm write
  // An ack outside the data stage leaves the flag alone
  always_ff @(posedge sys_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      ctl_tx_ready <= 1'b1;
      ctl_in_data <= 1'b0;
    end else begin
      if (usb_ev_i.ctl_data_stage) begin
        ctl_in_data <= 1'b1;
        ctl_tx_ready <= 1'b0;
      end else if (wr_lane0 && aw_addr == OFF_PKT_READY && wr_byte[CTL_TX_BIT]) begin
        ctl_tx_ready <= 1'b1;
      end else if (usb_ev_i.ctl_tx_ack && ctl_in_data && ctl_tx_ready) begin
        ctl_tx_ready <= 1'b0;
      end
    end
  end

  // Endpoint 1..3 transmit flags; once armed, only a host ack or a spell as receiver frees the FIFO again
  // A receiver parks its flag high so it never raises a tx request
  // The first cycle as transmitter frees the FIFO without an ack
  always_ff @(posedge sys_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      ep_tx_ready <= 3'h7;
      ep_tx_first <= 3'h7;
    end else begin
      for (int i = 0; i < 3; i++) begin
        if (!ep_is_tx[i]) begin
          ep_tx_ready[i] <= 1'b1; // Receiver: no tx request
          ep_tx_first[i] <= 1'b1;
        end else if (ep_tx_first[i]) begin
          ep_tx_ready[i] <= 1'b0;
          ep_tx_first[i] <= 1'b0;
        end else if (wr_lane0 && aw_addr == OFF_PKT_READY && wr_byte[EP_TX_LSB + i]) begin
          ep_tx_ready[i] <= 1'b1;
        end else if (usb_ev_i.tx_ack[i] && ep_tx_ready[i]) begin
          ep_tx_ready[i] <= 1'b0;
        end
      end
    end
  end

  // Receive flags and byte counts; the set wins over a same-cycle clear
  // An endpoint set as transmitter ignores receive events
  // The count stays until the next clean packet replaces it
  always_ff @(posedge sys_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      ep_rx_ready <= 2'h0;
      rx_cnt <= '0;
    end else begin
      for (int i = 0; i < 2; i++) begin
        if (usb_ev_i.rx_eop_ok[i] && !ep_dir_tx[i]) begin
          ep_rx_ready[i] <= 1'b1;
          rx_cnt[i] <= usb_ev_i.rx_count[i];
        end else if (wr_lane0 && aw_addr == OFF_EP_STAT && wr_byte[EP_RX_LSB + i]) begin
          ep_rx_ready[i] <= 1'b0;
        end
      end
    end
  end

  // Pending enabled conditions: tx when writable, rx when waiting
  // Endpoint 1 and 2 tx causes count only while set as transmitter
  assign pend = {ep_rx_ready & rx_en, ~ep_tx_ready & irq_en2 & ep_is_tx,
                 ~ctl_tx_ready & ctl_in_data & irq_en_ctl};
  assign ev_vec = pend;
  assign rd_clr = (rd_fire && s_axi_araddr_i == OFF_IRQ_STAT) ? {ST_W{1'b1}} : '0;

  // Sticky status, cleared by reading it; a new event wins
  // Limitation: a cause still pending sets its bit again after the read
  always_ff @(posedge sys_clk_i or negedge resetn_i) begin
    if (!resetn_i) irq_stat <= '0;
    else irq_stat <= ev_vec | (irq_stat & ~rd_clr);
  end

  // Interrupt outputs and engine commands, all registered
  // The pin follows live conditions, not the sticky copy, so an arm write
  // drops it on the second edge after the write without a status read
  always_ff @(posedge sys_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      irq_out_n_o <= 1'b1;
      irq_o <= 1'b0;
      usb_cmd_o <= '0;
    end else begin
      irq_out_n_o <= ~|(pend & irq_mask);
      irq_o <= |(pend & irq_mask);
      usb_cmd_o.ctl_send <= wr_lane0 && aw_addr == OFF_PKT_READY && wr_byte[CTL_TX_BIT];
      usb_cmd_o.ep_send <= (wr_lane0 && aw_addr == OFF_PKT_READY) ? wr_byte[2:0] : 3'h0;
      usb_cmd_o.rx_free <= (wr_lane0 && aw_addr == OFF_EP_STAT) ? wr_byte[1:0] & ep_rx_ready : 2'h0;
    end
  end
endmodule

// File: sim/uepr_host_model.sv
// Host and USB engine model facing the packet-ready block.
// Assumes the bench calls its tasks; answers armed packets itself.
module uepr_host_model
  import uepr_pkg::*;
(
  // Clock
  input wire logic sys_clk_i,
  // Block side
  input wire uepr_pkg::uepr_usb_cmd_t usb_cmd_i,
  output uepr_pkg::uepr_usb_ev_t usb_ev_o
);
  timeunit 1ns;
  timeprecision 100ps;
  int ack_dly = 6; // Host turnaround, the bench may make it slow or prompt
  int cnt [4]; // Countdown to ACK per channel, 0 idle
  logic [3:0] sends; // Control, then endpoints 1..3
  assign sends = {usb_cmd_i.ep_send, usb_cmd_i.ctl_send};
  initial usb_ev_o = '0;
  // Host ACKs every armed packet once the turnaround has run out
  always @(posedge sys_clk_i) begin
    usb_ev_o.ctl_tx_ack <= cnt[0] == 1;
    for (int i = 0; i < 3; i++) usb_ev_o.tx_ack[i] <= cnt[i+1] == 1;
    for (int i = 0; i < 4; i++) cnt[i] <= sends[i] ? ack_dly : (cnt[i] > 0 ? cnt[i] - 1 : 0);
  end
  // Clean packet of n bytes, ended by its EOP, full or short alike
  task automatic rx_pkt(input int ep, input logic [CNT_W-1:0] n);
    @(posedge sys_clk_i);
    usb_ev_o.rx_count[ep] <= n;
    usb_ev_o.rx_eop_ok[ep] <= 1'b1;
    @(posedge sys_clk_i);
    usb_ev_o.rx_eop_ok[ep] <= 1'b0;
  endtask
  // Control read passes from setup into data stage
  task automatic ctl_stage();
    @(posedge sys_clk_i);
    usb_ev_o.ctl_data_stage <= 1'b1;
    @(posedge sys_clk_i);
    usb_ev_o.ctl_data_stage <= 1'b0;
  endtask
endmodule

// File: sim/uepr_top_props.sv
// Checker for the packet-ready block, watching its ports only.
// Assumes one clock domain and the bind at the foot of this file.
module uepr_props
  import uepr_pkg::*;
(
  // Clock and reset
  input wire logic sys_clk_i,
  input wire logic resetn_i,
  // Register bus
  input wire logic s_axi_awvalid_i,
  input wire logic s_axi_awready_o,
  input wire logic s_axi_wvalid_i,
  input wire logic s_axi_wready_o,
  input wire logic s_axi_bvalid_o,
  input wire logic s_axi_bready_i,
  input wire logic [7:0] s_axi_araddr_i,
  input wire logic s_axi_arvalid_i,
  input wire logic s_axi_arready_o,
  input wire logic [1:0] s_axi_rresp_o,
  input wire logic s_axi_rvalid_o,
  input wire logic s_axi_rready_i,
  // Engine and interrupt
  input wire uepr_pkg::uepr_usb_cmd_t usb_cmd_o,
  input wire logic irq_out_n_o,
  input wire logic irq_o
);
  timeunit 1ns;
  timeprecision 100ps;
  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (!resetn_i);
  logic [7:0] rd_addr; // Address of the read in flight
  logic [3:0] since_wr; // Cycles since the last write data, saturating
  // Latch read address, its response is judged later
  always_ff @(posedge sys_clk_i or negedge resetn_i) begin
    if (!resetn_i) rd_addr <= 8'h00;
    else if (s_axi_arvalid_i && s_axi_arready_o) rd_addr <= s_axi_araddr_i;
  end
  // Only writes may drop the interrupt or command the engine
  always_ff @(posedge sys_clk_i or negedge resetn_i) begin
    if (!resetn_i) since_wr <= 4'hf;
    else if (s_axi_wvalid_i && s_axi_wready_o) since_wr <= 4'h0;
    else if (since_wr != 4'hf) since_wr <= since_wr + 4'h1;
  end
  irq_pair_a: assert property (irq_o == !irq_out_n_o) else $error("irq pins disagree");
  irq_fall_a: assert property ($fell(irq_o) |-> since_wr < 4'h8)
    else $error("irq dropped without a write");
  cmd_cause_a: assert property (usb_cmd_o != '0 |-> since_wr < 4'h5)
    else $error("engine command without a write");
  rd_resp_a: assert property (s_axi_rvalid_o |-> s_axi_rresp_o ==
    ((rd_addr[1:0] == 2'h0 && rd_addr <= 8'h24) ? RESP_OKAY : RESP_SLVERR))
    else $error("wrong read response");
  rd_answer_a: assert property (s_axi_arvalid_i && s_axi_arready_o |-> ##[1:2] s_axi_rvalid_o)
    else $error("read answer missing");
  wr_answer_a: assert property (s_axi_awvalid_i && s_axi_awready_o |-> ##[1:3] s_axi_bvalid_o)
    else $error("write answer missing");
  bvalid_hold_a: assert property (s_axi_bvalid_o && !s_axi_bready_i |=> s_axi_bvalid_o)
    else $error("bvalid dropped early");
  rvalid_hold_a: assert property (s_axi_rvalid_o && !s_axi_rready_i |=> s_axi_rvalid_o)
    else $error("rvalid dropped early");
  irq_seen_c: cover property ($rose(irq_o));
  ctl_send_c: cover property (usb_cmd_o.ctl_send);
  refused_c: cover property (s_axi_rvalid_o && s_axi_rresp_o == RESP_SLVERR);
endmodule

bind uepr_top uepr_props i_uepr_props (.*);

// File: sim/testbench.sv
// Bench for the endpoint packet-ready interrupt block.
// Assumes the host model acks armed packets after its turnaround.
module testbench;
  timeunit 1ns;
  timeprecision 100ps;
  import uepr_pkg::*;
  logic sys_clk_i, resetn_i, s_axi_awvalid_i, s_axi_wvalid_i, s_axi_bready_i;
  logic s_axi_arvalid_i, s_axi_rready_i, s_axi_awready_o, s_axi_wready_o, s_axi_bvalid_o;
  logic s_axi_arready_o, s_axi_rvalid_o, irq_out_n_o, irq_o;
  logic [7:0] s_axi_awaddr_i, s_axi_araddr_i;
  logic [31:0] s_axi_wdata_i, s_axi_rdata_o, d;
  logic [3:0] s_axi_wstrb_i;
  logic [1:0] s_axi_bresp_o, s_axi_rresp_o, r;
  uepr_usb_ev_t usb_ev_i;
  uepr_usb_cmd_t usb_cmd_o;
  int fails, n_tests, cycles, sends;
  logic [2:0] ep_seen = 3'h0; // Endpoint send pulses seen so far
  logic [1:0] free_seen = 2'h0; // Rx FIFO release pulses seen so far
  uepr_top i_uepr_top (.*);
  uepr_host_model i_host (.sys_clk_i(sys_clk_i), .usb_cmd_i(usb_cmd_o), .usb_ev_o(usb_ev_i));
  initial begin
    sys_clk_i = 1'b0;
    forever #4 sys_clk_i = ~sys_clk_i;
  end
  // Count cycles for the hang limit, and control packets armed
  always @(posedge sys_clk_i) begin
    cycles++;
    if (usb_cmd_o.ctl_send) sends++;
    ep_seen <= ep_seen | usb_cmd_o.ep_send;
    free_seen <= free_seen | usb_cmd_o.rx_free;
    if (cycles == 20000) begin
      fails++;
      complete_run();
    end
  end
  task automatic complete_run();
    $display("Checks %0d, mismatches %0d", n_tests, fails);
    if (fails == 0 && n_tests > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    n_tests++;
    if (got !== exp) begin
      fails++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask
  // One write, both halves offered together, each released when taken
  task automatic wr(input logic [7:0] a, input logic [31:0] v, input logic [1:0] er = RESP_OKAY);
    @(posedge sys_clk_i);
    s_axi_awaddr_i <= a;
    s_axi_wdata_i <= v;
    s_axi_awvalid_i <= 1'b1;
    s_axi_wvalid_i <= 1'b1;
    s_axi_bready_i <= 1'b1;
    fork
      begin do @(posedge sys_clk_i); while (!s_axi_awready_o); s_axi_awvalid_i <= 1'b0; end
      begin do @(posedge sys_clk_i); while (!s_axi_wready_o); s_axi_wvalid_i <= 1'b0; end
    join
    while (!s_axi_bvalid_o) @(posedge sys_clk_i);
    s_axi_bready_i <= 1'b0;
    chk("bresp", {30'h0, er}, {30'h0, s_axi_bresp_o});
  endtask
  task automatic rd(input logic [7:0] a);
    @(posedge sys_clk_i);
    s_axi_araddr_i <= a;
    s_axi_arvalid_i <= 1'b1;
    s_axi_rready_i <= 1'b1;
    do @(posedge sys_clk_i); while (!s_axi_arready_o);
    s_axi_arvalid_i <= 1'b0;
    do @(posedge sys_clk_i); while (!s_axi_rvalid_o);
    d = s_axi_rdata_o;
    r = s_axi_rresp_o;
    s_axi_rready_i <= 1'b0;
  endtask
  task automatic rchk(input logic [7:0] a, input logic [31:0] exp);
    rd(a);
    chk($sformatf("reg %h", a), exp, d);
    chk("rresp", {30'h0, RESP_OKAY}, {30'h0, r});
  endtask
  // Interrupt pins, after the registered update has landed
  task automatic ichk(input logic e);
    repeat (2) @(posedge sys_clk_i);
    chk("irq", {31'h0, e}, {31'h0, irq_o});
    chk("irq_n", {31'h0, !e}, {31'h0, irq_out_n_o});
  endtask
  task automatic t_reset();
    rchk(OFF_IRQ_MASK, 32'h3f);
    rchk(OFF_PKT_READY, 32'h10);
    rchk(OFF_EP_DIR, 32'h30);
    ichk(1'b0);
    rd(8'h40);
    chk("rresp unmapped", {30'h0, RESP_SLVERR}, {30'h0, r});
    wr(8'h02, 32'h1, RESP_SLVERR);
  endtask
  task automatic t_rx();
    wr(OFF_RX_EN, 32'h1);
    i_host.rx_pkt(1, 7'd64);
    rchk(OFF_EP_STAT, 32'h2);
    ichk(1'b0);
    i_host.rx_pkt(0, 7'd5);
    rchk(OFF_EP_STAT, 32'h3);
    ichk(1'b1);
    rchk(OFF_RX_CNT1, 32'h5);
    rchk(OFF_RX_CNT2, 32'h40);
    rchk(OFF_IRQ_STAT, 32'h10);
    wr(OFF_IRQ_MASK, 32'h0);
    ichk(1'b0);
    wr(OFF_IRQ_MASK, 32'h3f);
    ichk(1'b1);
    wr(OFF_EP_STAT, 32'h1);
    rchk(OFF_EP_STAT, 32'h2);
    chk("rx free", 32'h1, {30'h0, free_seen});
    ichk(1'b0);
    rchk(OFF_IRQ_STAT, 32'h10);
    rchk(OFF_IRQ_STAT, 32'h0);
    wr(OFF_EP_STAT, 32'h2);
    rchk(OFF_EP_STAT, 32'h0);
    chk("rx free", 32'h3, {30'h0, free_seen});
  endtask
  task automatic t_ctl();
    int s0;
    i_host.ack_dly = 20;
    wr(OFF_IRQ_EN, 32'h10);
    i_host.ctl_stage();
    rchk(OFF_PKT_READY, 32'h0);
    ichk(1'b1);
    s0 = sends;
    wr(OFF_PKT_READY, 32'h10);
    ichk(1'b0);
    chk("ctl sends", s0 + 1, sends);
    rchk(OFF_PKT_READY, 32'h10);
    repeat (20) @(posedge sys_clk_i);
    rchk(OFF_PKT_READY, 32'h0);
    ichk(1'b1);
    wr(OFF_IRQ_EN, 32'h0);
    ichk(1'b0);
  endtask
  task automatic t_eptx();
    i_host.ack_dly = 30;
    wr(OFF_IRQ_EN2, 32'h4);
    wr(OFF_EP_DIR, 32'h3);
    rchk(OFF_EP_DIR, 32'h3);
    ichk(1'b1);
    wr(OFF_PKT_READY, 32'h4);
    ichk(1'b0);
    chk("ep sends", 32'h4, {29'h0, ep_seen});
    wr(OFF_IRQ_EN2, 32'h7);
    ichk(1'b1);
    wr(OFF_PKT_READY, 32'h3);
    ichk(1'b0);
    chk("ep sends", 32'h7, {29'h0, ep_seen});
    repeat (30) @(posedge sys_clk_i);
    rchk(OFF_EP_DIR, 32'h3);
    ichk(1'b1);
  endtask
  initial begin
    {resetn_i, s_axi_awvalid_i, s_axi_wvalid_i, s_axi_bready_i} = '0;
    {s_axi_arvalid_i, s_axi_rready_i, s_axi_awaddr_i, s_axi_araddr_i} = '0;
    s_axi_wdata_i = 32'h0;
    s_axi_wstrb_i = 4'hf;
    repeat (2) @(posedge sys_clk_i);
    resetn_i <= 1'b1;
    @(posedge sys_clk_i);
    t_reset();
    t_rx();
    t_ctl();
    t_eptx();
    complete_run();
  end
endmodule
